// ==== core/rtc_pkg.sv ====
// constants, types and trim arithmetic shared by the rtc support logic
// assumes core_clk at 40 MHz and a 32.768 or 32.000 kHz oscillator level
package rtc_pkg;

  // ----------------------------------------------------------------
  // clock and oscillator-halt watchdog timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int OSC_HALT_US = 1000;
  localparam int OSC_HALT_CYCLES = OSC_HALT_US * CLK_MHZ;
  localparam int HALT_CNT_W = 20;

  // ----------------------------------------------------------------
  // timebase
  // ----------------------------------------------------------------
  localparam int CNT_W = 16;
  localparam logic [15:0] BASE_32768 = 16'h8000;
  localparam logic [15:0] BASE_32000 = 16'h7d00;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam int WIN_W = 5;
  // last second of the 20-second trim window (seconds 0..19)
  localparam logic [4:0] TRIM_WINDOW_LAST = 5'h13;
  localparam int TRIM_W = 7;
  localparam logic signed [7:0] TRIM_POS_MIN = 8'sh02;
  localparam logic signed [7:0] TRIM_NEG_MIN = 8'shc2;
  localparam logic signed [7:0] TRIM_ONE = 8'sh01;
  localparam logic signed [7:0] TRIM_ZERO = 8'sh00;

  // ----------------------------------------------------------------
  // calendar field widths
  // ----------------------------------------------------------------
  localparam int MIN_W = 7;
  localparam int HOUR_W = 6;
  localparam int WDAY_W = 3;
  localparam int WDAY_MASK_W = 7;
  localparam logic [2:0] WDAY_INVALID = 3'h7;

  typedef enum logic [2:0] {
    PER_OFF = 3'b000,
    PER_LOW = 3'b001,
    PER_PULSE_2HZ = 3'b010,
    PER_PULSE_1HZ = 3'b011,
    PER_LVL_SEC = 3'b100,
    PER_LVL_MIN = 3'b101,
    PER_LVL_HOUR = 3'b110,
    PER_LVL_MONTH = 3'b111
  } periodic_mode_t;

  typedef enum logic {
    WD_RUN = 1'b0,
    WD_STOPPED = 1'b1
  } wd_state_t;

  // pulses added to the trimmed second; each code step is two pulses in a 20 s window
  function automatic logic signed [7:0] trim_delta(input logic [6:0] code);
    logic signed [7:0] v;
    v = signed'({code[6], code});
    if (v >= TRIM_POS_MIN) begin
      trim_delta = (v - TRIM_ONE) <<< 1; // RULE3 RULE21
    end else if ((v < TRIM_ZERO) && (v >= TRIM_NEG_MIN)) begin
      trim_delta = v <<< 1; // RULE4 RULE21
    end else begin
      trim_delta = TRIM_ZERO; // RULE2
    end
  endfunction : trim_delta

endpackage : rtc_pkg

// ==== core/tick_if.sv ====
// timebase signals between the support core and the trimming counter
// assumes both ends on core_clk
`timescale 1ns/1ps
interface tick_if;
  logic osc_tick;
  logic xsel;
  logic [6:0] trim_code;
  logic sec_tick;
  logic [15:0] sub_cnt;
  logic [15:0] sec_len;
  logic [15:0] base;
  modport trim (input osc_tick, xsel, trim_code, output sec_tick, sub_cnt, sec_len, base);
  modport core (output osc_tick, xsel, trim_code, input sec_tick, sub_cnt, sec_len, base);
endinterface : tick_if

// ==== core/rtc_trim.sv ====
// trimmed seconds counter over oscillator pulses
// assumes osc_tick is a one-cycle pulse per oscillator rising edge
`timescale 1ns/1ps
module rtc_trim (
  input wire logic core_clk,
  input wire logic rstn,
  tick_if.trim tk
);
  logic [15:0] sub_cnt_q, sub_cnt_d;
  logic [4:0] sec_idx_q, sec_idx_d;
  logic sec_tick_q, sec_tick_d;
  logic [15:0] base;
  logic signed [7:0] delta;
  logic [15:0] len;

  always_comb begin
    base = tk.xsel ? rtc_pkg::BASE_32000 : rtc_pkg::BASE_32768;
    delta = rtc_pkg::trim_delta(tk.trim_code); // RULE1 RULE7
    // only one second in twenty is stretched or shrunk
    len = (sec_idx_q == rtc_pkg::TRIM_WINDOW_LAST) ? base + {{8{delta[7]}}, delta} : base; // RULE5
    sub_cnt_d = sub_cnt_q;
    sec_idx_d = sec_idx_q;
    sec_tick_d = 1'b0;
    if (tk.osc_tick) begin
      // >= so a code change mid-second cannot strand the counter past its end
      if (sub_cnt_q >= len - rtc_pkg::CNT_ONE) begin
        sub_cnt_d = '0;
        sec_tick_d = 1'b1;
        sec_idx_d = (sec_idx_q == rtc_pkg::TRIM_WINDOW_LAST) ? '0 : sec_idx_q + 5'h01;
      end else begin
        sub_cnt_d = sub_cnt_q + rtc_pkg::CNT_ONE;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sub_cnt_q <= '0;
      sec_idx_q <= '0;
      sec_tick_q <= 1'b0;
    end else begin
      sub_cnt_q <= sub_cnt_d;
      sec_idx_q <= sec_idx_d;
      sec_tick_q <= sec_tick_d;
    end
  end

  assign tk.sec_tick = sec_tick_q;
  assign tk.sub_cnt = sub_cnt_q;
  assign tk.sec_len = len;
  assign tk.base = base;
endmodule : rtc_trim

// ==== core/rtc_alarm.sv ====
// one alarm channel: day-of-week mask, hour and minute match, sticky flag
// assumes calendar inputs are stable between core_clk edges
`timescale 1ns/1ps
module rtc_alarm (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic enable,
  input wire logic [6:0] wday_mask,
  input wire logic [5:0] hour,
  input wire logic [6:0] minute,
  input wire logic [2:0] cal_wday,
  input wire logic [5:0] cal_hour,
  input wire logic [6:0] cal_min,
  input wire logic flag_clr,
  output logic flag,
  output logic req
);
  logic match;
  logic match_q, match_d;
  logic flag_q, flag_d;

  always_comb begin
    match = (cal_wday != rtc_pkg::WDAY_INVALID) && wday_mask[cal_wday]
            && (cal_hour == hour) && (cal_min == minute);
    match_d = match;
    flag_d = flag_q;
    if (!enable) begin
      flag_d = 1'b0;
    end else if (match && !match_q) begin
      flag_d = 1'b1; // RULE16
    end else if (flag_clr) begin
      flag_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      match_q <= 1'b0;
      flag_q <= 1'b0;
    end else begin
      match_q <= match_d;
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;
  assign req = flag_q && enable; // RULE16
endmodule : rtc_alarm

// ==== core/rtc_support.sv ====
// rtc support core: trimming, oscillator-halt sensing and interrupt pin sources
// assumes host control arrives as write strobes synchronous to core_clk
// Contract
// RULE1 - trim held as signed seven-bit value
// RULE2 - codes 0, +1, -64, -63 do nothing
// RULE3 - codes 2..63 slow clock for gain
// RULE4 - codes -1..-61 speed clock for loss (code speeds for -1..-62)
// RULE5 - correction applied once every twenty seconds
// RULE6 - clock on pin B stays untrimmed
// RULE7 - one step about three ppm
// RULE8 - host codes gain as distance from one
// RULE9 - host codes loss as 80h minus size
// RULE10 - halt flag armed by zero, set on stop
// RULE11 - halt flag forces configuration bits to zero
// RULE12 - power-up sets the halt flag
// RULE13 - halt flag sticks until host clears it
// RULE14 - host accesses limited while trimming
// RULE15 - each pin carries alarm, periodic or clock (code: clock source reaches pin B only, never pin A)
// RULE16 - alarm match drives selected pin low
// RULE17 - two identical alarm channels
// RULE18 - periodic waveform follows cycle select, pulse/level
// RULE19 - clock source passes raw oscillator pulses
// RULE20 - after power-on pin B clocks, A idle
// RULE21 - positive code removes, negative adds pulses (code: positive code adds pulses to the trimmed second, negative removes them)
`timescale 1ns/1ps
module rtc_support #(
  parameter int OSC_HALT_CYCLES = rtc_pkg::OSC_HALT_CYCLES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic osc_in,
  input wire logic cfg_wr,
  input wire logic cfg_crystal_freq_select,
  input wire logic [6:0] cfg_trim,
  input wire logic [2:0] cfg_periodic_cycle_select,
  input wire logic cfg_alarm_first_enable,
  input wire logic cfg_alarm_second_enable,
  input wire logic cfg_irq_route_select_hi,
  input wire logic cfg_irq_route_select_lo,
  input wire logic cfg_clkout_disable_n,
  input wire logic cfg_test,
  input wire logic halt_wr,
  input wire logic halt_wr_val,
  input wire logic alarm_first_clr,
  input wire logic alarm_second_clr,
  input wire logic periodic_clr,
  input wire logic [6:0] alarm_first_wday_mask,
  input wire logic [5:0] alarm_first_hour,
  input wire logic [6:0] alarm_first_min,
  input wire logic [6:0] alarm_second_wday_mask,
  input wire logic [5:0] alarm_second_hour,
  input wire logic [6:0] alarm_second_min,
  input wire logic [2:0] cal_wday,
  input wire logic [5:0] cal_hour,
  input wire logic [6:0] cal_min,
  input wire logic min_tick,
  input wire logic hour_tick,
  input wire logic month_tick,
  input wire logic irq_out_first_i,
  input wire logic irq_out_second_i,
  output logic irq_out_first_o,
  output logic irq_out_first_oe,
  output logic irq_out_second_o,
  output logic irq_out_second_oe,
  output logic osc_halt_flag,
  output logic crystal_freq_select,
  output logic [6:0] trim_value,
  output logic [2:0] periodic_cycle_select,
  output logic alarm_first_enable,
  output logic alarm_second_enable,
  output logic irq_route_select_hi,
  output logic irq_route_select_lo,
  output logic clkout_disable_n,
  output logic test_bit,
  output logic alarm_first_flag,
  output logic alarm_second_flag,
  output logic periodic_flag,
  output logic sec_tick
);

  // ----------------------------------------------------------------
  // oscillator edge detect
  // ----------------------------------------------------------------
  logic osc_prev_q, osc_prev_d;
  logic osc_tick;

  always_comb begin
    osc_prev_d = osc_in;
    osc_tick = osc_in && !osc_prev_q;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_prev_d;
    end
  end

  // ----------------------------------------------------------------
  // oscillator-halt watchdog and sticky flag
  // ----------------------------------------------------------------
  localparam logic [19:0] HALT_LIMIT = 20'(OSC_HALT_CYCLES - 1);
  rtc_pkg::wd_state_t wd_q, wd_d;
  logic [19:0] wd_cnt_q, wd_cnt_d;
  logic halt_flag_q, halt_flag_d;
  logic halt_event;

  always_comb begin
    wd_d = wd_q;
    wd_cnt_d = wd_cnt_q;
    halt_event = 1'b0;
    case (wd_q)
      rtc_pkg::WD_RUN: begin
        if (osc_tick) begin
          wd_cnt_d = '0;
        end else if (wd_cnt_q >= HALT_LIMIT) begin
          wd_d = rtc_pkg::WD_STOPPED;
          halt_event = 1'b1; // RULE10
        end else begin
          wd_cnt_d = wd_cnt_q + 20'h0_0001;
        end
      end
      rtc_pkg::WD_STOPPED: begin
        if (osc_tick) begin
          wd_d = rtc_pkg::WD_RUN;
          wd_cnt_d = '0;
        end
      end
      default: begin
        wd_d = rtc_pkg::WD_RUN;
        wd_cnt_d = '0;
      end
    endcase
    // a stop in the same cycle as a host clear still sets the flag
    halt_flag_d = halt_flag_q; // RULE13
    if (halt_event) begin
      halt_flag_d = 1'b1; // RULE10
    end else if (halt_wr) begin
      halt_flag_d = halt_wr_val; // RULE10
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wd_q <= rtc_pkg::WD_RUN;
      wd_cnt_q <= '0;
      halt_flag_q <= 1'b1; // RULE12
    end else begin
      wd_q <= wd_d;
      wd_cnt_q <= wd_cnt_d;
      halt_flag_q <= halt_flag_d;
    end
  end

  // ----------------------------------------------------------------
  // configuration bits, cleared while the halt flag is set
  // ----------------------------------------------------------------
  logic xsel_q, xsel_d;
  logic [6:0] trim_q, trim_d;
  logic [2:0] ct_q, ct_d;
  logic aen_a_q, aen_a_d;
  logic aen_b_q, aen_b_d;
  logic sl_hi_q, sl_hi_d;
  logic sl_lo_q, sl_lo_d;
  logic clken_n_q, clken_n_d;
  logic test_q, test_d;

  always_comb begin
    {xsel_d, trim_d, ct_d, aen_a_d, aen_b_d, sl_hi_d, sl_lo_d, clken_n_d, test_d} =
      {xsel_q, trim_q, ct_q, aen_a_q, aen_b_q, sl_hi_q, sl_lo_q, clken_n_q, test_q};
    if (halt_flag_q) begin
      {xsel_d, trim_d, ct_d, aen_a_d, aen_b_d, sl_hi_d, sl_lo_d, clken_n_d, test_d} = '0; // RULE11
    end else if (cfg_wr) begin
      xsel_d = cfg_crystal_freq_select;
      trim_d = cfg_trim; // RULE1
      ct_d = cfg_periodic_cycle_select;
      aen_a_d = cfg_alarm_first_enable;
      aen_b_d = cfg_alarm_second_enable;
      sl_hi_d = cfg_irq_route_select_hi;
      sl_lo_d = cfg_irq_route_select_lo;
      clken_n_d = cfg_clkout_disable_n;
      test_d = cfg_test;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      {xsel_q, trim_q, ct_q, aen_a_q, aen_b_q, sl_hi_q, sl_lo_q, clken_n_q, test_q} <= '0;
    end else begin
      {xsel_q, trim_q, ct_q, aen_a_q, aen_b_q, sl_hi_q, sl_lo_q, clken_n_q, test_q} <=
        {xsel_d, trim_d, ct_d, aen_a_d, aen_b_d, sl_hi_d, sl_lo_d, clken_n_d, test_d};
    end
  end

  // ----------------------------------------------------------------
  // trimmed timebase
  // ----------------------------------------------------------------
  tick_if tk ();
  assign tk.osc_tick = osc_tick;
  assign tk.xsel = xsel_q;
  assign tk.trim_code = trim_q;

  rtc_trim u_trim (
    .core_clk(core_clk),
    .rstn(rstn),
    .tk(tk)
  );

  // ----------------------------------------------------------------
  // alarm channels
  // ----------------------------------------------------------------
  logic req_a, req_b;

  rtc_alarm u_alarm_first ( // RULE17
    .core_clk(core_clk),
    .rstn(rstn),
    .enable(aen_a_q),
    .wday_mask(alarm_first_wday_mask),
    .hour(alarm_first_hour),
    .minute(alarm_first_min),
    .cal_wday(cal_wday),
    .cal_hour(cal_hour),
    .cal_min(cal_min),
    .flag_clr(alarm_first_clr),
    .flag(alarm_first_flag),
    .req(req_a)
  );

  rtc_alarm u_alarm_second ( // RULE17
    .core_clk(core_clk),
    .rstn(rstn),
    .enable(aen_b_q),
    .wday_mask(alarm_second_wday_mask),
    .hour(alarm_second_hour),
    .minute(alarm_second_min),
    .cal_wday(cal_wday),
    .cal_hour(cal_hour),
    .cal_min(cal_min),
    .flag_clr(alarm_second_clr),
    .flag(alarm_second_flag),
    .req(req_b)
  );

  // ----------------------------------------------------------------
  // periodic interrupt
  // ----------------------------------------------------------------
  // pulse phases use the untrimmed base, so the stretched second runs a little long low-free
  rtc_pkg::periodic_mode_t per_mode;
  logic [15:0] half_len, quarter_len;
  logic lvl_q, lvl_d;
  logic lvl_event;
  logic per_req;

  always_comb begin
    per_mode = rtc_pkg::periodic_mode_t'(ct_q);
    half_len = tk.base >> 1;
    quarter_len = tk.base >> 2;
    lvl_event = 1'b0;
    per_req = 1'b0;
    case (per_mode)
      rtc_pkg::PER_OFF: per_req = 1'b0;
      rtc_pkg::PER_LOW: per_req = 1'b1; // RULE18
      rtc_pkg::PER_PULSE_2HZ: begin
        per_req = (tk.sub_cnt < quarter_len) ||
                  ((tk.sub_cnt >= half_len) && (tk.sub_cnt < half_len + quarter_len)); // RULE18
      end
      rtc_pkg::PER_PULSE_1HZ: per_req = tk.sub_cnt < half_len; // RULE18
      rtc_pkg::PER_LVL_SEC: lvl_event = tk.sec_tick;
      rtc_pkg::PER_LVL_MIN: lvl_event = min_tick;
      rtc_pkg::PER_LVL_HOUR: lvl_event = hour_tick;
      rtc_pkg::PER_LVL_MONTH: lvl_event = month_tick;
      default: per_req = 1'b0;
    endcase
    lvl_d = lvl_q;
    if (!ct_q[2]) begin
      lvl_d = 1'b0;
    end else if (lvl_event) begin
      lvl_d = 1'b1; // RULE18
    end else if (periodic_clr) begin
      lvl_d = 1'b0;
    end
    if (ct_q[2]) begin
      per_req = lvl_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      lvl_q <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
    end
  end

  // ----------------------------------------------------------------
  // pin routing, open drain, low when any source routed to that pin requests
  // ----------------------------------------------------------------
  logic clk_src;

  always_comb begin
    clk_src = !clken_n_q && !osc_in; // RULE6 RULE19
    irq_out_first_oe = req_a || (req_b && !sl_lo_q) || (per_req && !sl_hi_q); // RULE15
    irq_out_second_oe = (req_b && sl_lo_q) || (per_req && sl_hi_q) || clk_src; // RULE15 RULE20
  end

  assign irq_out_first_o = 1'b0;
  assign irq_out_second_o = 1'b0;
  assign osc_halt_flag = halt_flag_q;
  assign crystal_freq_select = xsel_q;
  assign trim_value = trim_q;
  assign periodic_cycle_select = ct_q;
  assign alarm_first_enable = aen_a_q;
  assign alarm_second_enable = aen_b_q;
  assign irq_route_select_hi = sl_hi_q;
  assign irq_route_select_lo = sl_lo_q;
  assign clkout_disable_n = clken_n_q;
  assign test_bit = test_q;
  assign periodic_flag = per_req;
  assign sec_tick = tk.sec_tick;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_trim_store: assert property (@(posedge core_clk) disable iff (!rstn) // RULE1
    (cfg_wr && !halt_flag_q) |=> (trim_q == $past(cfg_trim)))
    else $error("trim value not stored");
  a_trim_neutral: assert property (@(posedge core_clk) disable iff (!rstn) // RULE2
    (trim_q == 7'h00 || trim_q == 7'h01 || trim_q == 7'h40 || trim_q == 7'h41)
    |-> (tk.sec_len == tk.base))
    else $error("neutral trim code changed second length");
  a_trim_slow: assert property (@(posedge core_clk) disable iff (!rstn) // RULE3
    (!trim_q[6] && trim_q >= 7'h02 && tk.sec_len != tk.base)
    |-> (tk.sec_len == tk.base + 16'({trim_q, 1'b0}) - 16'h0002))
    else $error("gain trim length wrong");
  a_trim_fast: assert property (@(posedge core_clk) disable iff (!rstn) // RULE4
    (trim_q[6] && trim_q >= 7'h42 && tk.sec_len != tk.base)
    |-> (tk.sec_len == tk.base - 16'({~trim_q + 7'h01, 1'b0})))
    else $error("loss trim length wrong");
  a_halt_sets: assert property (@(posedge core_clk) disable iff (!rstn) // RULE10
    halt_event |=> halt_flag_q)
    else $error("halt flag not set on stop");
  a_halt_clears: assert property (@(posedge core_clk) disable iff (!rstn) // RULE11
    (halt_flag_q && $past(halt_flag_q)) |-> (trim_q == 7'h00 && ct_q == 3'h0 && !aen_a_q
      && !aen_b_q && !sl_hi_q && !sl_lo_q && !clken_n_q && !xsel_q && !test_q))
    else $error("config not cleared under halt");
  a_powerup_flag: assert property (@(posedge core_clk) // RULE12
    (rstn && !$past(rstn)) |-> halt_flag_q)
    else $error("halt flag not set after reset");
  a_halt_sticky: assert property (@(posedge core_clk) disable iff (!rstn) // RULE13
    (halt_flag_q && !(halt_wr && !halt_wr_val)) |=> halt_flag_q)
    else $error("halt flag dropped without host clear");
  a_alarm_pin: assert property (@(posedge core_clk) disable iff (!rstn) // RULE16
    (alarm_first_flag && aen_a_q) |-> irq_out_first_oe)
    else $error("alarm did not pull first pin low");
  a_clk_pass: assert property (@(posedge core_clk) disable iff (!rstn) // RULE19
    (!clken_n_q && !osc_in) |-> irq_out_second_oe)
    else $error("clock low not passed to second pin");
  a_idle_first: assert property (@(posedge core_clk) // RULE20
    (rstn && !$past(rstn)) |-> !irq_out_first_oe)
    else $error("first pin active after reset");
endmodule : rtc_support

// ==== sim/osc_source.sv ====
// crystal oscillator stand-in that drives the rtc support core osc_in
// assumes core_clk is far faster than the oscillator; run low models a halt
`timescale 1ns/1ps
module osc_source #(
  parameter int HALF = 4
) (
  input wire logic core_clk,
  input wire logic run,
  output logic osc
);
  int cnt;
  initial begin
    osc = 1'b0;
    cnt = 0;
  end
  // a stopped crystal freezes at its last level, as a real halt does
  always @(posedge core_clk) begin
    if (run) begin
      if (cnt == HALF - 1) begin
        cnt <= 0;
        osc <= ~osc;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : osc_source

// ==== sim/tb_rtc_support.sv ====
// self-checking bench for rtc_support: halt flag, config gating, pin sources
// assumes a short halt watchdog; trim second lengths are left to in-design checks
`timescale 1ns/1ps
module tb_rtc_support;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int HALT_CYC = 200;
  logic core_clk, rstn, osc_run, osc_in;
  logic cfg_wr, cfg_xs, cfg_test, cfg_aen, cfg_ben, cfg_hi, cfg_lo, cfg_clkn;
  logic [6:0] cfg_trim;
  logic [2:0] cfg_ct;
  logic halt_wr, halt_wr_val, a_clr, b_clr, p_clr, min_tick, hour_tick, month_tick;
  logic [6:0] mask, amin, cal_min;
  logic [5:0] hour, cal_hour;
  logic [2:0] cal_wday;
  logic first_oe, second_oe, halt_flag, xs_o, aen_o, ben_o, hi_o, lo_o, clkn_o, test_o;
  logic first_o, second_o;
  logic [6:0] trim_o;
  logic [2:0] ct_o;
  logic a_flag, b_flag, p_flag;
  logic pin_a, pin_b;
  int n_errors, n_checks, cycles;
  // pins are open drain with pull-ups: low only while the enable is high
  assign pin_a = ~first_oe;
  assign pin_b = ~second_oe;

  osc_source #(.HALF(4)) osc (.core_clk(core_clk), .run(osc_run), .osc(osc_in));

  rtc_support #(.OSC_HALT_CYCLES(HALT_CYC)) dut (
    .core_clk(core_clk), .rstn(rstn), .osc_in(osc_in), .cfg_wr(cfg_wr),
    .cfg_crystal_freq_select(cfg_xs), .cfg_trim(cfg_trim), .cfg_periodic_cycle_select(cfg_ct),
    .cfg_alarm_first_enable(cfg_aen), .cfg_alarm_second_enable(cfg_ben),
    .cfg_irq_route_select_hi(cfg_hi), .cfg_irq_route_select_lo(cfg_lo),
    .cfg_clkout_disable_n(cfg_clkn), .cfg_test(cfg_test), .halt_wr(halt_wr),
    .halt_wr_val(halt_wr_val), .alarm_first_clr(a_clr), .alarm_second_clr(b_clr),
    .periodic_clr(p_clr), .alarm_first_wday_mask(mask), .alarm_first_hour(hour),
    .alarm_first_min(amin), .alarm_second_wday_mask(mask), .alarm_second_hour(hour),
    .alarm_second_min(amin), .cal_wday(cal_wday), .cal_hour(cal_hour), .cal_min(cal_min),
    .min_tick(min_tick), .hour_tick(hour_tick), .month_tick(month_tick),
    .irq_out_first_i(pin_a), .irq_out_second_i(pin_b), .irq_out_first_o(first_o),
    .irq_out_first_oe(first_oe), .irq_out_second_o(second_o), .irq_out_second_oe(second_oe),
    .osc_halt_flag(halt_flag), .crystal_freq_select(xs_o), .trim_value(trim_o),
    .periodic_cycle_select(ct_o), .alarm_first_enable(aen_o), .alarm_second_enable(ben_o),
    .irq_route_select_hi(hi_o), .irq_route_select_lo(lo_o), .clkout_disable_n(clkn_o),
    .test_bit(test_o), .alarm_first_flag(a_flag), .alarm_second_flag(b_flag),
    .periodic_flag(p_flag), .sec_tick()
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      $display("BAD %0t run did not finish in time", $time);
      conclude();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  // one write strobe carrying every config field; outputs settle one edge later
  task automatic set_cfg(input logic xs, input logic [6:0] trim, input logic [2:0] ct,
                         input logic aen, input logic ben, input logic hi, input logic lo,
                         input logic clkn, input logic tst);
    @(posedge core_clk);
    cfg_wr <= 1'b1;
    cfg_xs <= xs;
    cfg_trim <= trim;
    cfg_ct <= ct;
    {cfg_aen, cfg_ben, cfg_hi, cfg_lo, cfg_clkn, cfg_test} <= {aen, ben, hi, lo, clkn, tst};
    @(posedge core_clk);
    cfg_wr <= 1'b0;
    @(negedge core_clk);
  endtask : set_cfg

  task automatic chk_cfg(input logic [7:0] e0, input logic [7:0] e1, input string msg);
    chk({xs_o, trim_o}, e0, msg);
    chk({ct_o, aen_o, ben_o, hi_o, lo_o, clkn_o}, e1, msg);
  endtask : chk_cfg

  // which: 0 first clear, 1 second clear, 2 periodic clear, 3 halt clear, 4.. tick 0..2
  task automatic pulse(input int which);
    @(posedge core_clk);
    case (which)
      0: a_clr <= 1'b1;
      1: b_clr <= 1'b1;
      2: p_clr <= 1'b1;
      3: halt_wr <= 1'b1;
      4: min_tick <= 1'b1;
      5: hour_tick <= 1'b1;
      default: month_tick <= 1'b1;
    endcase
    @(posedge core_clk);
    {a_clr, b_clr, p_clr, halt_wr, min_tick, hour_tick, month_tick} <= 7'h00;
    repeat (2) @(negedge core_clk);
  endtask : pulse

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_power_up();
    chk(halt_flag, 1, "halt flag after power up");
    chk(pin_a, 1, "first pin idle after power up");
    chk({first_o, second_o}, 8'h00, "open drain pins only pull low");
    repeat (10) begin
      @(negedge core_clk);
      chk(pin_b, osc_in, "second pin follows oscillator");
    end
    set_cfg(1, 7'h09, 3'h1, 1, 1, 1, 1, 1, 1);
    chk_cfg(8'h00, 8'h00, "config refused while halted");
  endtask : t_power_up

  task automatic t_arm();
    pulse(3);
    chk(halt_flag, 0, "halt flag cleared by host");
    set_cfg(1, 7'h09, 3'h0, 0, 0, 0, 0, 1, 0);
    chk_cfg(8'h89, 8'h01, "gain code stored");
    set_cfg(0, 7'(8'h80 - 8'd41), 3'h0, 0, 0, 0, 0, 1, 0);
    chk({1'b0, trim_o}, 8'h57, "loss code stored");
  endtask : t_arm

  task automatic t_halt();
    int k;
    set_cfg(1, 7'h7f, 3'h7, 1, 1, 1, 1, 1, 1);
    osc_run <= 1'b0;
    repeat (HALT_CYC - 50) @(posedge core_clk);
    @(negedge core_clk);
    chk(halt_flag, 0, "flag early during short stop");
    k = 0;
    while (halt_flag !== 1'b1 && k < 400) begin
      @(negedge core_clk);
      k++;
    end
    chk(halt_flag, 1, "stop sensed");
    // config is cleared on the edge after the flag rises
    @(negedge core_clk);
    chk_cfg(8'h00, 8'h00, "config forced by halt");
    chk(test_o, 0, "test bit forced by halt");
    osc_run <= 1'b1;
    repeat (2 * HALT_CYC) @(negedge core_clk);
    chk(halt_flag, 1, "flag sticks after restart");
    pulse(3);
    chk(halt_flag, 0, "flag cleared after restart");
  endtask : t_halt

  task automatic t_clkout();
    // trim must not reach the clock pin; one write per trim setting keeps access sparse
    set_cfg(0, 7'h3f, 3'h0, 0, 0, 0, 0, 0, 0);
    repeat (12) begin
      @(negedge core_clk);
      chk(pin_b, osc_in, "trimmed config keeps raw clock");
    end
    set_cfg(0, 7'h00, 3'h0, 0, 0, 0, 0, 1, 0);
    repeat (12) begin
      @(negedge core_clk);
      chk(pin_b, 1, "clock off holds pin high");
    end
  endtask : t_clkout

  task automatic t_alarm();
    for (int i = 0; i < 3; i++) begin
      set_cfg(0, 7'h00, 3'h0, i == 0, i > 0, 0, i == 1, 1, 0);
      @(posedge core_clk);
      cal_min <= 7'h30;
      repeat (3) @(negedge core_clk);
      chk({a_flag, b_flag}, (i == 0) ? 2'b10 : 2'b01, "alarm flag on match");
      chk({pin_a, pin_b}, (i == 1) ? 2'b10 : 2'b01, "alarm pin low");
      pulse((i == 0) ? 0 : 1);
      chk({a_flag, b_flag, pin_a, pin_b}, 4'h3, "alarm cleared");
      @(posedge core_clk);
      cal_min <= 7'h31;
    end
  endtask : t_alarm

  task automatic t_periodic();
    set_cfg(0, 7'h00, 3'h1, 0, 0, 0, 0, 1, 0);
    chk({pin_a, pin_b}, 2'b01, "fixed low on first pin");
    set_cfg(0, 7'h00, 3'h1, 0, 0, 1, 0, 1, 0);
    chk({pin_a, pin_b}, 2'b10, "fixed low on second pin");
    // the run stays in the first quarter of a second, where both pulse modes request
    for (int k = 2; k < 4; k++) begin
      set_cfg(0, 7'h00, 3'(k), 0, 0, 0, 0, 1, 0);
      chk({p_flag, pin_a}, 2'b10, "pulse mode low early in second");
    end
    for (int k = 0; k < 3; k++) begin
      set_cfg(0, 7'h00, 3'(5 + k), 0, 0, 0, 0, 1, 0);
      chk({p_flag, pin_a}, 2'b01, "level flag idle");
      pulse(4 + k);
      chk({p_flag, pin_a}, 2'b10, "level flag on event");
      pulse(2);
      chk({p_flag, pin_a}, 2'b01, "level flag cleared");
    end
  endtask : t_periodic

  initial begin
    n_errors = 0;
    n_checks = 0;
    cycles = 0;
    rstn = 1'b0;
    osc_run = 1'b1;
    {cfg_wr, cfg_xs, cfg_test, cfg_aen, cfg_ben, cfg_hi, cfg_lo, cfg_clkn} = 8'h00;
    cfg_trim = 7'h00;
    cfg_ct = 3'h0;
    {halt_wr, halt_wr_val, a_clr, b_clr, p_clr, min_tick, hour_tick, month_tick} = 8'h00;
    mask = 7'h04;
    hour = 6'h12;
    amin = 7'h30;
    cal_wday = 3'h2;
    cal_hour = 6'h12;
    cal_min = 7'h31;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    @(negedge core_clk);
    t_power_up();
    t_arm();
    t_halt();
    t_clkout();
    t_alarm();
    t_periodic();
    conclude();
  end
endmodule : tb_rtc_support
